// file: src/phli_consts.svh
// named constants for the link interface start-up block
// assumes a 125 MHz core clock and an 8-bit data path
`ifndef PHLI_CONSTS_SVH
`define PHLI_CONSTS_SVH

// core clock period in ns
`define PHLI_CLK_PERIOD_NS 8
// restore wait the link side keeps before raising power status, in us
`define PHLI_RESTORE_WAIT_US 15
// clock wake time from low power, in ns (5.3 ms .. 7.3 ms)
`define PHLI_WAKE_MIN_NS 5300000
`define PHLI_WAKE_MAX_NS 7300000
// longest clock restart time when not in low power, in ns
`define PHLI_FAST_MAX_NS 60
// derived cycle counts: least time rounds up, longest rounds down
`define PHLI_WAKE_MIN_CYC ((`PHLI_WAKE_MIN_NS + `PHLI_CLK_PERIOD_NS - 1) / `PHLI_CLK_PERIOD_NS)
`define PHLI_FAST_MAX_CYC (`PHLI_FAST_MAX_NS / `PHLI_CLK_PERIOD_NS)
// wake counter width
`define PHLI_WAKE_W 20
// phase accumulator for the 49.152 MHz interface clock
// increment = 2 * 49.152 / 125 * 2^24, one carry per half period
`define PHLI_ACC_W 24
`define PHLI_ACC_INC 24'hC9539C
// interface clock cycle numbers in the start-up sequence
`define PHLI_CYC_W 4
`define PHLI_CYC_LOW 4'h1
`define PHLI_CYC_RECV 4'h8
// control line codes and data patterns
`define PHLI_CTL_IDLE 2'h0
`define PHLI_CTL_RECV 2'h1
`define PHLI_DATA_ZERO 8'h00
`define PHLI_DATA_ONES 8'hFF
// number of pins that pass the synchroniser
`define PHLI_SYNC_W 3

`endif

// file: src/phli_pkg.sv
// types shared by the link interface start-up block
// assumes phli_consts.svh is on the include path
`include "phli_consts.svh"

package phli_pkg;

  // control and data lines toward the link controller
  typedef struct packed {
    logic [1:0] ctl;
    logic [7:0] data;
  } phli_bus_t;

  // pins sampled from outside the clock domain
  typedef struct packed {
    logic power;
    logic request;
    logic iso;
  } phli_pins_t;

  // start-up sequencer states
  typedef enum logic [3:0] {
    PHLI_S_RESET = 4'h1,
    PHLI_S_WAKE = 4'h2,
    PHLI_S_INIT = 4'h4,
    PHLI_S_RUN = 4'h8
  } phli_state_t;

endpackage

// file: src/phli_sync.sv
// two flip-flop synchroniser for the asynchronous link pins
// assumes the pins are quasi-static against the 8 ns core clock
`timescale 1ns/1ps
`include "phli_consts.svh"

module phli_sync
  import phli_pkg::*;
(
  input wire logic clk, // core clock
  input wire logic rst, // synchronous reset, active high
  input wire phli_pins_t pins_in, // raw pin levels
  output phli_pins_t pins_out // synchronised levels
);

  phli_pins_t stage1_reg;
  phli_pins_t stage1_next;
  phli_pins_t stage2_reg;
  phli_pins_t stage2_next;

  // first stage feeds only the second
  always_comb begin
    stage1_next = pins_in;
    stage2_next = stage1_reg;
  end

  // register both stages
  always_ff @(posedge clk) begin
    if (rst) begin
      stage1_reg <= '0;
      stage2_reg <= '0;
    end else begin
      stage1_reg <= stage1_next;
      stage2_reg <= stage2_next;
    end
  end

  assign pins_out = stage2_reg;

endmodule

// file: src/phli_clkgen.sv
// interface clock generator from a phase accumulator
// assumes run is a registered level from the sequencer on the same clock
`timescale 1ns/1ps
`include "phli_consts.svh"

module phli_clkgen (
  input wire logic clk, // core clock
  input wire logic rst, // synchronous reset, active high
  input wire logic run, // keep the interface clock toggling
  output logic clk_level, // interface clock level
  output logic rise // one-cycle pulse on each rising edge
);

  logic [`PHLI_ACC_W-1:0] acc_reg;
  logic [`PHLI_ACC_W-1:0] acc_next;
  logic level_reg;
  logic level_next;
  logic rise_reg;
  logic rise_next;
  logic [`PHLI_ACC_W:0] sum;

  // carry out of the accumulator marks each half period
  always_comb begin
    sum = {1'b0, acc_reg} + {1'b0, `PHLI_ACC_INC};
    acc_next = acc_reg;
    level_next = level_reg;
    rise_next = 1'b0;
    if (!run) begin
      acc_next = '0;
      level_next = 1'b0;
    end else begin
      acc_next = sum[`PHLI_ACC_W-1:0];
      if (sum[`PHLI_ACC_W]) begin
        level_next = !level_reg; // starts low for a half period
        rise_next = !level_reg;
      end
    end
  end

  // register accumulator and clock level
  always_ff @(posedge clk) begin
    if (rst) begin
      acc_reg <= '0;
      level_reg <= 1'b0;
      rise_reg <= 1'b0;
    end else begin
      acc_reg <= acc_next;
      level_reg <= level_next;
      rise_reg <= rise_next;
    end
  end

  assign clk_level = level_reg;
  assign rise = rise_reg;

endmodule

// file: src/phli_top.sv
// start-up sequencer of the parallel link interface, device end
// assumes the reset/disable logic drives the two request levels on this clock
`timescale 1ns/1ps
`include "phli_consts.svh"

module phli_top
  import phli_pkg::*;
#(
  parameter int WAKE_CYCLES = `PHLI_WAKE_MIN_CYC // low-power clock wake delay
) (
  input wire logic clk, // core clock, 125 MHz
  input wire logic rst, // synchronous reset, active high
  input wire logic link_power_status, // power status pin from link side
  input wire logic link_request_line, // request pin from link side
  input wire logic iso_select, // isolation select pin, high = non-differentiated
  input wire logic phy_low_power, // device sits in its low-power state
  input wire logic iface_reset_req, // hold the interface in reset
  input wire logic iface_disable_req, // stop the interface clock
  output logic interface_clock_out, // interface clock level
  output logic interface_clock_oe, // interface clock driven
  output phli_bus_t interface_bus_out, // control and data line levels
  output logic interface_bus_oe, // control and data lines driven
  output logic init_done, // start-up complete, requests accepted
  output logic link_request // accepted request line level
);

  phli_pins_t pins_raw;
  phli_pins_t pins_sync;
  phli_state_t state_reg;
  phli_state_t state_next;
  logic run_reg;
  logic run_next;
  logic power_d_reg;
  logic power_d_next;
  logic [`PHLI_WAKE_W-1:0] wake_cnt_reg;
  logic [`PHLI_WAKE_W-1:0] wake_cnt_next;
  logic [`PHLI_CYC_W-1:0] cyc_reg;
  logic [`PHLI_CYC_W-1:0] cyc_next;
  logic [`PHLI_CYC_W-1:0] cyc_inc;
  phli_bus_t bus_reg;
  phli_bus_t bus_next;
  logic bus_oe_reg;
  logic bus_oe_next;
  logic clk_oe_reg;
  logic clk_oe_next;
  logic done_reg;
  logic done_next;
  logic req_reg;
  logic req_next;
  logic power_rise;
  logic non_diff;
  logic clk_level;
  logic clk_rise;

  // builds the word shown on control and data lines
  function automatic phli_bus_t phli_word(input logic [1:0] ctl, input logic [7:0] data);
    phli_word.ctl = ctl;
    phli_word.data = data;
  endfunction

  // asynchronous pins pass two flip-flops first
  always_comb begin
    pins_raw.power = link_power_status;
    pins_raw.request = link_request_line;
    pins_raw.iso = iso_select;
  end

  phli_sync u_sync (
    .clk(clk),
    .rst(rst),
    .pins_in(pins_raw),
    .pins_out(pins_sync)
  );

  phli_clkgen u_clkgen (
    .clk(clk),
    .rst(rst),
    .run(run_reg),
    .clk_level(clk_level),
    .rise(clk_rise)
  );

  // mode select and power status edge
  assign non_diff = pins_sync.iso;
  assign power_rise = pins_sync.power && !power_d_reg;
  assign cyc_inc = cyc_reg + `PHLI_CYC_W'(1);

  // sequencer next state and line values
  always_comb begin
    state_next = state_reg;
    run_next = run_reg;
    power_d_next = pins_sync.power;
    wake_cnt_next = wake_cnt_reg;
    cyc_next = cyc_reg;
    bus_next = bus_reg;
    bus_oe_next = bus_oe_reg;
    done_next = done_reg;
    case (state_reg)
      PHLI_S_RESET: begin
        // lines low; differentiated mode leaves them floating
        bus_next = phli_word(`PHLI_CTL_IDLE, `PHLI_DATA_ZERO);
        bus_oe_next = non_diff;
        done_next = 1'b0;
        cyc_next = '0;
        wake_cnt_next = '0;
        if (iface_disable_req) begin
          run_next = 1'b0;
        end
        if (power_rise) begin
          // wake delay only if disabled and in low power; reset only skips it
          if (!run_reg && phy_low_power) begin
            state_next = PHLI_S_WAKE;
          end else begin
            run_next = 1'b1; // first clock rise comes three cycles after the synchronised pin goes high
            state_next = PHLI_S_INIT;
          end
        end
      end
      PHLI_S_WAKE: begin
        bus_oe_next = non_diff;
        wake_cnt_next = wake_cnt_reg + `PHLI_WAKE_W'(1);
        if (!pins_sync.power) begin
          state_next = PHLI_S_RESET;
        end else if (wake_cnt_reg == `PHLI_WAKE_W'(WAKE_CYCLES - 1)) begin
          run_next = 1'b1;
          state_next = PHLI_S_INIT;
        end
      end
      PHLI_S_INIT: begin
        if (iface_reset_req) begin
          state_next = PHLI_S_RESET;
        end else if (clk_rise) begin
          cyc_next = cyc_inc;
          if (cyc_inc == `PHLI_CYC_LOW) begin
            bus_next = phli_word(`PHLI_CTL_IDLE, `PHLI_DATA_ZERO);
            bus_oe_next = 1'b1;
          end else if (cyc_inc < `PHLI_CYC_RECV) begin
            bus_next = phli_word(`PHLI_CTL_IDLE, `PHLI_DATA_ZERO);
            bus_oe_next = non_diff;
          end else if (cyc_inc == `PHLI_CYC_RECV) begin
            bus_next = phli_word(`PHLI_CTL_RECV, `PHLI_DATA_ONES);
            bus_oe_next = 1'b1;
          end else begin
            bus_next = phli_word(`PHLI_CTL_IDLE, `PHLI_DATA_ZERO);
            bus_oe_next = 1'b1;
            done_next = 1'b1;
            state_next = PHLI_S_RUN;
          end
        end
      end
      PHLI_S_RUN: begin
        if (iface_reset_req) begin
          done_next = 1'b0;
          state_next = PHLI_S_RESET;
        end else if (clk_rise && !non_diff) begin
          bus_oe_next = 1'b0; // release after one driven cycle
        end
      end
      default: begin
        state_next = PHLI_S_RESET;
      end
    endcase
    // differentiated mode floats a stopped clock, the other mode drives it low
    clk_oe_next = non_diff || run_next;
    // requests only pass once start-up is complete
    req_next = pins_sync.request && done_next;
  end

  // register sequencer state; hardware reset leaves the interface disabled
  always_ff @(posedge clk) begin
    if (rst) begin
      state_reg <= PHLI_S_RESET;
      run_reg <= 1'b0;
      power_d_reg <= 1'b0;
      wake_cnt_reg <= '0;
      cyc_reg <= '0;
      bus_reg <= '0;
      bus_oe_reg <= 1'b0;
      clk_oe_reg <= 1'b0;
      done_reg <= 1'b0;
      req_reg <= 1'b0;
    end else begin
      state_reg <= state_next;
      run_reg <= run_next;
      power_d_reg <= power_d_next;
      wake_cnt_reg <= wake_cnt_next;
      cyc_reg <= cyc_next;
      bus_reg <= bus_next;
      bus_oe_reg <= bus_oe_next;
      clk_oe_reg <= clk_oe_next;
      done_reg <= done_next;
      req_reg <= req_next;
    end
  end

  // outputs come from flip-flops
  assign interface_clock_out = clk_level;
  assign interface_clock_oe = clk_oe_reg;
  assign interface_bus_out = bus_reg;
  assign interface_bus_oe = bus_oe_reg;
  assign init_done = done_reg;
  assign link_request = req_reg;

endmodule

// file: dv/phli_props.sv
// port checker for the start-up sequencer
// assumes binding to phli_top on the core clock
`timescale 1ns/1ps
module phli_props
  import phli_pkg::*;
#(
  parameter int WAKE_CYCLES = 20 // wake delay
) (
  input wire logic clk, // core clock
  input wire logic rst, // sync reset
  input wire logic link_power_status, // power pin
  input wire logic link_request_line, // request pin
  input wire logic iso_select, // mode pin
  input wire logic phy_low_power, // low power
  input wire logic iface_reset_req, // reset req
  input wire logic iface_disable_req, // disable req
  input wire logic interface_clock_out, // if clock
  input wire logic interface_clock_oe, // clock oe
  input wire phli_bus_t interface_bus_out, // ctl/data
  input wire logic interface_bus_oe, // bus oe
  input wire logic init_done, // done
  input wire logic link_request // accepted req
);
  default clocking cb @(posedge clk); endclocking
  default disable iff (rst);
  bus_code_a: assert property (!init_done && interface_bus_oe |-> interface_bus_out inside {10'h000, 10'h1FF})
    else $error("bus code not zero or receive in start-up");
  recv_first_a: assert property ($rose(init_done) |-> $past(interface_bus_out) == 10'h1FF)
    else $error("receive code missing before done");
  idle_done_a: assert property ($rose(init_done) |-> interface_bus_oe && interface_bus_out == 10'h000)
    else $error("idle code missing at done");
  req_gate_a: assert property (!init_done && !$past(init_done) |-> !link_request)
    else $error("request passed before done");
  done_hold_a: assert property (init_done && !iface_reset_req |=> init_done)
    else $error("done dropped without reset request");
  nondiff_drive_a: assert property ($fell(interface_bus_oe) |-> !$past(iso_select, 4))
    else $error("bus released in non-differentiated mode");
  diff_release_a: assert property ($rose(init_done) && !iso_select |-> ##[1:4] !interface_bus_oe)
    else $error("bus not released in differentiated mode");
  clk_high_a: assert property ($rose(interface_clock_out) |-> ##[1:2] !interface_clock_out)
    else $error("clock high phase too long");
  clk_low_a: assert property ($fell(interface_clock_out) && init_done |-> ##[1:2] interface_clock_out)
    else $error("clock low phase too long");
  clk_start_a: assert property ($rose(interface_clock_oe) |-> !interface_clock_out [*2])
    else $error("clock not low at restart");
  cover property ($rose(init_done) && !iso_select);
  cover property ($rose(init_done) && iso_select);
  cover property ($rose(link_request));
endmodule

bind phli_top phli_props #(.WAKE_CYCLES(WAKE_CYCLES)) u_props (.clk, .rst, .link_power_status,
  .link_request_line, .iso_select, .phy_low_power, .iface_reset_req, .iface_disable_req,
  .interface_clock_out, .interface_clock_oe, .interface_bus_out, .interface_bus_oe,
  .init_done, .link_request);

// file: dv/phli_link_model.sv
// link controller model: power status and request pins
// assumes go and req_in from the bench, own 80 ns clock
`timescale 1ns/1ps
module phli_link_model #(
  parameter int RESTORE_CYC = 188 // 15 us of 80 ns
) (
  input wire logic lclk, // link clock
  input wire logic go, // start-up asked
  input wire logic req_in, // request asked
  output logic power, // power status pin
  output logic request, // request pin
  output logic ll_oe // link drives its control and data lines low
);
  int wait_cnt;
  logic power_q;
  initial begin
    power = 1'b0;
    request = 1'b0;
    ll_oe = 1'b0;
    power_q = 1'b0;
    wait_cnt = 0;
  end
  // power rises only after the restore wait spent low
  always @(posedge lclk) begin
    if (!go) begin
      power <= #2 1'b0;
      wait_cnt <= 0;
    end else if (wait_cnt < RESTORE_CYC) begin
      wait_cnt <= wait_cnt + 1;
    end else begin
      power <= #2 1'b1;
    end
  end
  // request low and lines driven low for one link clock as power rises
  always @(posedge lclk) begin
    power_q <= power;
    ll_oe <= #2 power && !power_q;
    request <= #2 req_in && !(power && !power_q);
  end
endmodule

// file: dv/phli_top_tb_top.sv
// testbench of the start-up sequencer
// assumes the bench stands in for the reset/disable logic
`timescale 1ns/1ps
module phli_top_tb_top import phli_pkg::*;;
  localparam int WAKE = 20;
  logic clk, rst, lclk, go, req_in, iso, low_pwr, rst_req, dis_req;
  logic power, request, ck_out, ck_oe, bus_oe, done, acc_req, ll_oe;
  phli_bus_t bus;
  int n_errors, cmp_count;
  int lat, nr, dr, er, k, hi, cr;
  phli_top #(.WAKE_CYCLES(WAKE)) uut (.clk(clk), .rst(rst), .link_power_status(power),
    .link_request_line(request), .iso_select(iso), .phy_low_power(low_pwr), .iface_reset_req(rst_req),
    .iface_disable_req(dis_req), .interface_clock_out(ck_out), .interface_clock_oe(ck_oe),
    .interface_bus_out(bus), .interface_bus_oe(bus_oe), .init_done(done), .link_request(acc_req));
  phli_link_model link (.lclk(lclk), .go(go), .req_in(req_in), .power(power), .request(request),
    .ll_oe(ll_oe));
  // core and link clocks, unrelated phases
  initial begin
    clk = 1'b0;
    forever #4 clk = ~clk;
  end
  initial begin
    lclk = 1'b0;
    #13;
    forever #40 lclk = ~lclk;
  end
  task automatic tick();
    @(posedge clk);
    #1;
  endtask
  task automatic check(input string name, input logic [31:0] seen, input logic [31:0] exp);
    cmp_count++;
    if (seen !== exp) begin
      n_errors++;
      $display("CHECK FAILED %s expected %0h seen %0h", name, exp, seen);
    end
  endtask
  task automatic stop_test();
    $display("errors %0d checks %0d", n_errors, cmp_count);
    if (n_errors == 0 && cmp_count > 0) begin
      $display("verification passed");
    end else begin
      $display("verification failed");
    end
    $finish;
  endtask
  // reset state, optional disable, then trace one start-up
  task automatic run_init(input logic dis);
    logic pck, poe, rcv;
    int t;
    lat = 0;
    nr = 0;
    dr = 0;
    er = 0;
    rcv = 1'b0;
    cr = 0;
    go = 1'b0;
    rst_req = 1'b1;
    t = 0;
    while (power !== 1'b0 && t < 40) begin
      tick();
      t++;
    end
    check("power_low", power, 0);
    repeat (4) tick();
    rst_req = 1'b0;
    dis_req = dis;
    repeat (4) tick();
    dis_req = 1'b0;
    go = 1'b1;
    t = 0;
    while (power !== 1'b1 && t < 4000) begin
      tick();
      t++;
    end
    check("restore", t >= 1875 && power === 1'b1, 1);
    pck = ck_out;
    poe = bus_oe;
    t = 0;
    while (done !== 1'b1 && t < 400) begin
      tick();
      t++;
      if (bus_oe === 1'b1 && bus === 10'h1FF) rcv = 1'b1;
      if (ck_out === 1'b1 && pck === 1'b0 && !rcv) begin
        if (nr == 0) lat = t;
        nr++;
      end
      if (bus_oe === 1'b0 && poe === 1'b1) dr++;
      if (acc_req !== 1'b0 && done !== 1'b1) er++;
      if (ll_oe === 1'b1 && bus_oe === 1'b1 && bus !== 10'h000) cr++;
      pck = ck_out;
      poe = bus_oe;
    end
  endtask
  task automatic t_after_reset();
    check("done", done, 0);
    check("request", acc_req, 0);
    check("bus", bus, 0);
    check("bus_oe", bus_oe, 0);
    check("clock_oe", ck_oe, 0);
  endtask
  // differentiated, disabled, not low power, early request
  task automatic t_diff_fast();
    req_in = 1'b1;
    run_init(1'b1);
    check("latency", lat >= 3 && lat <= 14, 1);
    check("rises", nr, 8);
    check("releases", dr > 0, 1);
    check("early_req", er, 0);
    check("contention", cr, 0);
    check("clock_oe", ck_oe, 1);
    check("done", done, 1);
    repeat (6) tick();
    check("request", acc_req, 1);
    check("bus_oe", bus_oe, 0);
    req_in = 1'b0;
  endtask
  // clock rate and duty over 10 us
  task automatic t_freq();
    logic pv;
    nr = 0;
    hi = 0;
    pv = ck_out;
    for (k = 0; k < 1250; k++) begin
      tick();
      if (ck_out === 1'b1) hi++;
      if (ck_out === 1'b1 && pv !== 1'b1) nr++;
      pv = ck_out;
    end
    check("rises", nr >= 491 && nr <= 492, 1);
    check("high", hi >= 620 && hi <= 630, 1);
  endtask
  // reset only, clock keeps running
  task automatic t_reset_only();
    run_init(1'b0);
    check("rises", nr >= 8 && nr <= 9, 1);
    check("done", done, 1);
  endtask
  // non-differentiated, low power wake
  task automatic t_nondiff_lp();
    go = 1'b0;
    rst = 1'b1;
    iso = 1'b1;
    low_pwr = 1'b1;
    repeat (12) tick();
    rst = 1'b0;
    repeat (4) tick();
    check("clock_oe", ck_oe, 1);
    check("bus_oe", bus_oe, 1);
    run_init(1'b1);
    check("latency", lat >= WAKE + 3 && lat <= WAKE + 14, 1);
    check("releases", dr, 0);
    check("contention", cr, 0);
    check("rises", nr, 8);
    check("done", done, 1);
    req_in = 1'b1;
    repeat (16) tick();
    check("request", acc_req, 1);
  endtask
  // watchdog
  initial begin
    #500000;
    n_errors++;
    stop_test();
  end
  initial begin
    rst = 1'b1;
    go = 1'b0;
    req_in = 1'b0;
    iso = 1'b0;
    low_pwr = 1'b0;
    rst_req = 1'b0;
    dis_req = 1'b0;
    n_errors = 0;
    cmp_count = 0;
    repeat (2) tick();
    rst = 1'b0;
    repeat (4) tick();
    t_after_reset();
    t_diff_fast();
    t_freq();
    t_reset_only();
    t_nondiff_lp();
    stop_test();
  end
endmodule
